// ### bench/acs_clk_partner.sv
// Purpose: Models the far gear that sends word, SPDIF and ADAT clocks.
// Assumes: A clock runs only while enabled and stands low otherwise.
// Notes: Pin bits are word, optical, coaxial, ADAT.
module acs_clk_partner (
	input wire logic [3:0] en_i,
	input int half_ns_i [4],
	output logic [3:0] pin_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ***************************************************************
	// Clock sources
	// ***************************************************************
	initial pin_o = 4'h0;
	for (genvar k = 0; k < 4; k++) begin : g_pin
		always begin
			#(half_ns_i[k]);
			pin_o[k] = en_i[k] ? ~pin_o[k] : 1'b0;
		end
	end
endmodule

// ### bench/acs_source_select_bench.sv
// Purpose: Self-checking bench of the clock source selector.
// Assumes: Partner clocks run at 400 ns unless changed.
// Notes: Fixed waits follow the lock and timeout figures.
module acs_source_select_bench
	import acs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// ***************************************************************
	// Design and partner
	// ***************************************************************
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [3:0] en = 4'h0;
	int half_ns [4] = '{200, 200, 200, 200};
	logic [3:0] pin;
	acs_src_t pref = ACS_SRC_INT;
	acs_spdif_cfg_t cfg = '0;
	acs_box_pins_t box = '0;
	logic single = 1'b0;
	logic disc = 1'b0;
	logic tx = 1'b0;
	logic cs = 1'b0;
	acs_src_t cur;
	acs_status_t w_st, s_st, a_st;
	acs_rate_t s_rate;
	acs_box_t b_st;
	logic [ACS_PW-1:0] s_per;
	logic w_clk, opt, link, coax;
	int bad_count = 0;
	int checks_done = 0;

	always #25 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		tx <= ~tx;
		cs <= tx;
	end
	acs_clk_partner far_u (.en_i(en), .half_ns_i(half_ns), .pin_o(pin));
	acs_source_select dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .word_clk_i(pin[0]), .spdif_opt_i(pin[1]),
		.spdif_coax_i(pin[2]), .adat_clk_i(pin[3]), .pref_src_i(pref), .spdif_cfg_i(cfg),
		.single_speed_i(single), .int_period_i(12'h008), .spdif_tx_i(tx), .rx_cs_i(cs), .rx_tm_i(tx),
		.box_pins_i(box), .box_disconnect_i(disc), .cur_src_o(cur), .word_status_o(w_st),
		.spdif_status_o(s_st), .adat_status_o(a_st), .spdif_period_o(s_per), .spdif_rate_o(s_rate),
		.word_clk_o(w_clk), .spdif_coax_o(coax), .spdif_opt_o(opt), .tx_cs_o(), .tx_tm_o(),
		.box_state_o(b_st), .box_link_en_o(link));
	// ***************************************************************
	// Tasks
	// ***************************************************************
	task automatic go();
		@(posedge clk_i);
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic high_time(input int exp);
		int n;
		int lost;
		lost = 0;
		for (n = 0; n < 3000 && w_clk !== 1'b0; n++) begin
			wait_n(1);
		end
		lost += (n == 3000);
		for (n = 0; n < 3000 && w_clk !== 1'b1; n++) begin
			wait_n(1);
		end
		lost += (n == 3000);
		for (n = 0; n < 3000 && w_clk === 1'b1; n++) begin
			wait_n(1);
		end
		lost += (n == 3000);
		if (lost != 0) begin
			$display("unexpected word clock: expected edges, seen none within bound");
			bad_count++;
			test_done();
		end else begin
			check("word clock high", 12'(exp), 12'(n));
		end
	endtask
	task automatic test_done();
		$display("checks %0d, mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// ***************************************************************
	// Tests
	// ***************************************************************
	initial begin
		#2000000;
		bad_count++;
		test_done();
	end
	initial begin
		repeat (8) @(posedge clk_i);
		rst_b_i <= 1'b1;
		wait_n(1);
		check("source", ACS_SRC_INT, cur);
		check("adat status", ACS_ST_NOLOCK, a_st);
		check("box state", ACS_BOX_ERROR, b_st);
		$display("test reset done");
		go();
		en <= 4'h9;
		wait_n(80);
		check("source", ACS_SRC_INT, cur);
		check("word status", ACS_ST_SYNC, w_st);
		go();
		pref <= ACS_SRC_SPDIF;
		wait_n(4);
		check("source", ACS_SRC_WORD, cur);
		go();
		half_ns[2] <= 300;
		en <= 4'hd;
		wait_n(100);
		check("source", ACS_SRC_SPDIF, cur);
		check("word status", ACS_ST_LOCK, w_st);
		check("adat status", ACS_ST_LOCK, a_st);
		go();
		en <= 4'h9;
		wait_n(1300);
		check("source", ACS_SRC_WORD, cur);
		go();
		pref <= ACS_SRC_ADAT;
		wait_n(4);
		check("source", ACS_SRC_ADAT, cur);
		go();
		en <= 4'h0;
		wait_n(1300);
		check("source", ACS_SRC_INT, cur);
		$display("test automatic done");
		go();
		pref <= ACS_SRC_SPDIF;
		en <= 4'h2;
		wait_n(100);
		check("spdif status", ACS_ST_NOLOCK, s_st);
		go();
		cfg.opt_sel <= 1'b1;
		wait_n(100);
		check("source", ACS_SRC_SPDIF, cur);
		go();
		cfg <= 3'h1;
		half_ns[2] <= 5200;
		en <= 4'h4;
		wait_n(1400);
		check("spdif period", 12'h0d0, s_per);
		check("spdif rate", 3'h6, s_rate);
		check("optical out", 1'b0, opt);
		high_time(104);
		go();
		single <= 1'b1;
		high_time(208);
		go();
		cfg <= 3'h3;
		wait_n(2);
		check("coaxial out", !tx, coax);
		check("optical out", coax, opt);
		$display("test spdif done");
		go();
		box <= 3'h4;
		wait_n(6);
		check("box state", ACS_BOX_DETECTED, b_st);
		go();
		box <= 3'h7;
		wait_n(6);
		check("box state", ACS_BOX_CONNECTED, b_st);
		go();
		disc <= 1'b1;
		wait_n(2);
		check("box state", ACS_BOX_DISCONNECTED, b_st);
		check("link enable", 1'b0, link);
		go();
		disc <= 1'b0;
		wait_n(6);
		check("box state", ACS_BOX_CONNECTED, b_st);
		go();
		box <= 3'h0;
		wait_n(6);
		check("box state", ACS_BOX_ERROR, b_st);
		$display("test box done");
		test_done();
	end
endmodule

// ### bench/acs_source_select_checker.sv
// Purpose: Port level assertions of the clock source selector.
// Assumes: One clock domain, reset active low.
// Notes: Latencies follow the hand-over contract.
module acs_source_select_checker
	import acs_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input acs_src_t pref_src_i,
	input acs_spdif_cfg_t spdif_cfg_i,
	input wire logic spdif_tx_i,
	input wire logic rx_cs_i,
	input wire logic rx_tm_i,
	input wire logic box_disconnect_i,
	input acs_src_t cur_src_o,
	input acs_status_t adat_status_o,
	input acs_rate_t spdif_rate_o,
	input wire logic spdif_coax_o,
	input wire logic spdif_opt_o,
	input wire logic tx_cs_o,
	input wire logic tx_tm_o,
	input acs_box_t box_state_o,
	input wire logic box_link_en_o
);
	// ***************************************************************
	// Assertions
	// ***************************************************************
	default clocking dc @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);
	coax_delay_a: assert property ($past(rst_b_i) |-> spdif_coax_o == $past(spdif_tx_i))
		else $error("coaxial output wrong");
	opt_gate_a: assert property ($past(rst_b_i) |-> spdif_opt_o == $past(spdif_tx_i & spdif_cfg_i.opt_out_en))
		else $error("optical output wrong");
	cs_gate_a: assert property ($past(rst_b_i) |-> tx_cs_o == $past(rx_cs_i & spdif_cfg_i.tms_en))
		else $error("channel status output wrong");
	tm_gate_a: assert property ($past(rst_b_i) |-> tx_tm_o == $past(rx_tm_i & spdif_cfg_i.tms_en))
		else $error("track marker output wrong");
	master_hold_a: assert property (pref_src_i == ACS_SRC_INT |=> cur_src_o == ACS_SRC_INT)
		else $error("master mode left internal clock");
	disc_wins_a: assert property (box_state_o == ACS_BOX_CONNECTED && box_disconnect_i |=>
		box_state_o == ACS_BOX_DISCONNECTED)
		else $error("disconnect ignored");
	error_exit_a: assert property (box_state_o == ACS_BOX_ERROR |=>
		box_state_o inside {ACS_BOX_ERROR, ACS_BOX_DETECTED})
		else $error("box left error wrongly");
	link_halt_a: assert property (box_disconnect_i && box_state_o != ACS_BOX_ERROR |=> !box_link_en_o)
		else $error("link enabled while disconnect held");
	adat_sync_a: assert property (cur_src_o == ACS_SRC_ADAT [*4] |-> adat_status_o == ACS_ST_SYNC)
		else $error("reference input not sync");
	cover property (cur_src_o == ACS_SRC_ADAT);
	cover property (box_state_o == ACS_BOX_DISCONNECTED);
	cover property (spdif_rate_o == 3'h6);
endmodule

bind acs_source_select acs_source_select_checker chk_u (.clk_i(clk_i), .rst_b_i(rst_b_i),
	.pref_src_i(pref_src_i), .spdif_cfg_i(spdif_cfg_i), .spdif_tx_i(spdif_tx_i), .rx_cs_i(rx_cs_i),
	.rx_tm_i(rx_tm_i), .box_disconnect_i(box_disconnect_i), .cur_src_o(cur_src_o),
	.adat_status_o(adat_status_o), .spdif_rate_o(spdif_rate_o), .spdif_coax_o(spdif_coax_o),
	.spdif_opt_o(spdif_opt_o), .tx_cs_o(tx_cs_o), .tx_tm_o(tx_tm_o), .box_state_o(box_state_o),
	.box_link_en_o(box_link_en_o));

// ### verilog/acs_input_monitor.sv
// Purpose: Synchronises one external clock, measures its period and judges lock.
// Assumes: The clock is slow enough that each level lasts at least two system cycles.
// Notes: Lock needs ACS_LOCK_CNT matching periods; a missing edge drops it.
module acs_input_monitor
	import acs_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic pin_i,
	output acs_mon_t mon_o
);

	// ***************************************************************
	// State
	// ***************************************************************
	typedef struct packed {
		logic [1:0] sync;
		logic prev;
		logic [ACS_PW-1:0] cnt;
		logic [2:0] good;
		acs_mon_t mon;
	} acs_mon_state_t;

	acs_mon_state_t s;
	acs_mon_state_t next_s;

	always_comb begin
		next_s = s;
		next_s.sync = {s.sync[0], pin_i};
		next_s.prev = s.sync[1];
		next_s.mon.rise = 1'b0;
		if (s.cnt != {ACS_PW{1'b1}}) begin
			next_s.cnt = s.cnt + 1'b1;
		end
		if (s.sync[1] && !s.prev) begin
			next_s.mon.rise = 1'b1;
			next_s.cnt = 12'h001;
			next_s.mon.period = s.cnt;
			if (s.cnt < ACS_TIMEOUT_CYC && acs_abs_diff(s.cnt, s.mon.period) <= ACS_PER_TOL) begin
				if (s.good != ACS_LOCK_CNT) begin
					next_s.good = s.good + 1'b1;
				end
				next_s.mon.locked = (next_s.good == ACS_LOCK_CNT);
			end else begin
				next_s.good = 3'h0;
				next_s.mon.locked = 1'b0;
			end
		end else if (s.cnt >= ACS_TIMEOUT_CYC) begin
			next_s.good = 3'h0;
			next_s.mon.locked = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign mon_o = s.mon;

endmodule

// ### verilog/acs_pkg.sv
// Purpose: Shared constants, types and helpers of the audio clock source selector.
// Assumes: The system clock runs at ACS_CLK_HZ; external clocks arrive at word rate.
// Notes: Periods are measured in system clock cycles.
package acs_pkg;

	// ***************************************************************
	// Widths and timing
	// ***************************************************************
	localparam int ACS_PW = 12;
	localparam int unsigned ACS_CLK_HZ = 20_000_000;
	localparam int unsigned ACS_SS_MAX_HZ = 48_000;
	localparam int unsigned ACS_SS_MIN_HZ = 32_000;
	// Halving starts clearly above the top single speed rate, so a jittery 48 kHz reference stays whole.
	localparam logic [ACS_PW-1:0] ACS_SS_LIMIT_CYC = ACS_PW'(ACS_CLK_HZ / ACS_SS_MAX_HZ - ACS_CLK_HZ / ACS_SS_MAX_HZ / 32);
	localparam logic [ACS_PW-1:0] ACS_TIMEOUT_CYC = ACS_PW'(2 * (ACS_CLK_HZ / ACS_SS_MIN_HZ));
	localparam logic [ACS_PW-1:0] ACS_PER_TOL = 12'h002;
	localparam logic [2:0] ACS_LOCK_CNT = 3'h4;
	localparam int unsigned ACS_NUM_RATES = 6;
	localparam int unsigned ACS_RATE_HZ [ACS_NUM_RATES] = '{32000, 44100, 48000, 64000, 88200, 96000};

	// ***************************************************************
	// Types
	// ***************************************************************
	typedef enum logic [1:0] {
		ACS_SRC_INT = 2'h0,
		ACS_SRC_WORD = 2'h1,
		ACS_SRC_SPDIF = 2'h2,
		ACS_SRC_ADAT = 2'h3
	} acs_src_t;

	typedef enum logic [1:0] {
		ACS_ST_NOLOCK = 2'h0,
		ACS_ST_LOCK = 2'h1,
		ACS_ST_SYNC = 2'h2
	} acs_status_t;

	typedef enum logic [1:0] {
		ACS_BOX_ERROR = 2'h0,
		ACS_BOX_DETECTED = 2'h1,
		ACS_BOX_CONNECTED = 2'h3,
		ACS_BOX_DISCONNECTED = 2'h2
	} acs_box_t;

	typedef logic [2:0] acs_rate_t;
	localparam acs_rate_t ACS_RATE_NONE = 3'h0;

	typedef struct packed {
		logic locked;
		logic rise;
		logic [ACS_PW-1:0] period;
	} acs_mon_t;

	typedef struct packed {
		logic opt_sel;
		logic opt_out_en;
		logic tms_en;
	} acs_spdif_cfg_t;

	typedef struct packed {
		logic present;
		logic fw_done;
		logic comm_ok;
	} acs_box_pins_t;

	localparam acs_src_t ACS_RST_SRC = ACS_SRC_INT;
	localparam acs_box_t ACS_RST_BOX = ACS_BOX_ERROR;

	// ***************************************************************
	// Helpers
	// ***************************************************************
	function automatic logic [ACS_PW-1:0] acs_abs_diff(input logic [ACS_PW-1:0] a, input logic [ACS_PW-1:0] b);
		return (a > b) ? a - b : b - a;
	endfunction

	// Maps a measured period to the nominal rate it lies within about 3 percent of.
	function automatic acs_rate_t acs_rate_of(input logic [ACS_PW-1:0] p);
		acs_rate_t r;
		logic [ACS_PW-1:0] nominal;
		r = ACS_RATE_NONE;
		for (int i = 0; i < ACS_NUM_RATES; i++) begin
			nominal = ACS_PW'(ACS_CLK_HZ / ACS_RATE_HZ[i]);
			if (acs_abs_diff(p, nominal) <= (p >> 5)) begin
				r = 3'(i + 1);
			end
		end
		return r;
	endfunction

endpackage

// ### verilog/acs_source_select.sv
// Purpose: Chooses the sample clock reference, reports input status and drives digital outputs.
// Assumes: External clocks and box pins are asynchronous; config bits come from the clk_i domain.
// Notes: A preferred source of internal means fixed master operation.
// Behaviour
// - Reference is internal, word, SPDIF or ADAT.
// - Unlocked preferred input falls back to locked one.
// - Nothing locked means internal oscillator reference.
// - Locked preferred input stays the reference.
// - Automatic mode follows valid inputs immediately.
// - Lost external reference reverts to internal master when no other input is locked.
// - Report the source in use separately.
// - Per-input status: no lock, lock, sync.
// - Word clock output follows current sample rate.
// - Single speed halves rates above 48 kHz.
// - SPDIF input from optical or coaxial port.
// - Measure and report received SPDIF sample rate.
// - Coaxial output always, optical when enabled.
// - Channel status and track marker gated.
// - All receivers run, one is reference.
// - Box link state error, detected, connected, disconnected.
// - Disconnect halts link, box runs alone.
module acs_source_select
	import acs_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic word_clk_i,
	input wire logic spdif_opt_i,
	input wire logic spdif_coax_i,
	input wire logic adat_clk_i,
	input acs_src_t pref_src_i,
	input acs_spdif_cfg_t spdif_cfg_i,
	input wire logic single_speed_i,
	input wire logic [ACS_PW-1:0] int_period_i,
	input wire logic spdif_tx_i,
	input wire logic rx_cs_i,
	input wire logic rx_tm_i,
	input acs_box_pins_t box_pins_i,
	input wire logic box_disconnect_i,
	output acs_src_t cur_src_o,
	output acs_status_t word_status_o,
	output acs_status_t spdif_status_o,
	output acs_status_t adat_status_o,
	output logic [ACS_PW-1:0] spdif_period_o,
	output acs_rate_t spdif_rate_o,
	output logic word_clk_o,
	output logic spdif_coax_o,
	output logic spdif_opt_o,
	output logic tx_cs_o,
	output logic tx_tm_o,
	output acs_box_t box_state_o,
	output logic box_link_en_o
);

	// ***************************************************************
	// Input monitors
	// ***************************************************************
	logic [2:0] in_pins;
	acs_mon_t [2:0] mon;

	// Index 0 is word clock, 1 is SPDIF, 2 is ADAT; all are watched at once.
	assign in_pins = {adat_clk_i, spdif_cfg_i.opt_sel ? spdif_opt_i : spdif_coax_i, word_clk_i};

	generate
		for (genvar g = 0; g < 3; g++) begin : gen_mon
			acs_input_monitor u_mon (
				.clk_i(clk_i),
				.rst_b_i(rst_b_i),
				.pin_i(in_pins[g]),
				.mon_o(mon[g])
			);
		end
	endgenerate

	// ***************************************************************
	// Helpers
	// ***************************************************************
	function automatic logic [1:0] src_idx(input acs_src_t src);
		case (src)
			ACS_SRC_WORD: return 2'h0;
			ACS_SRC_SPDIF: return 2'h1;
			ACS_SRC_ADAT: return 2'h2;
			default: return 2'h0;
		endcase
	endfunction

	function automatic logic src_locked(input acs_src_t src, input acs_mon_t [2:0] m);
		return (src != ACS_SRC_INT) && m[src_idx(src)].locked;
	endfunction

	// ***************************************************************
	// State
	// ***************************************************************
	typedef struct packed {
		acs_src_t cur_src;
		logic [ACS_PW-1:0] ref_period;
		acs_status_t [2:0] status;
		logic [ACS_PW-1:0] spdif_period;
		acs_rate_t spdif_rate;
		logic [ACS_PW-1:0] int_cnt;
		logic int_rise;
		logic wck;
		logic [ACS_PW:0] wck_cnt;
		logic ss_phase;
		logic coax;
		logic opt;
		logic tx_cs;
		logic tx_tm;
		acs_box_pins_t [1:0] box_sync;
		acs_box_t box;
	} acs_sel_state_t;

	acs_sel_state_t s;
	acs_sel_state_t next_s;

	logic ref_rise;
	logic halve;
	logic [ACS_PW:0] out_period;
	acs_box_pins_t box_pins;

	assign box_pins = s.box_sync[1];
	assign ref_rise = (s.cur_src == ACS_SRC_INT) ? s.int_rise : mon[src_idx(s.cur_src)].rise;
	assign halve = single_speed_i && (s.ref_period < ACS_SS_LIMIT_CYC);
	assign out_period = halve ? {s.ref_period, 1'b0} : {1'b0, s.ref_period};

	// ***************************************************************
	// Next state
	// ***************************************************************
	always_comb begin
		next_s = s;

		// Source choice.
		if (pref_src_i == ACS_SRC_INT) begin
			next_s.cur_src = ACS_SRC_INT;
		end else if (src_locked(pref_src_i, mon)) begin
			next_s.cur_src = pref_src_i;
		end else if (mon[0].locked) begin
			next_s.cur_src = ACS_SRC_WORD;
		end else if (mon[1].locked) begin
			next_s.cur_src = ACS_SRC_SPDIF;
		end else if (mon[2].locked) begin
			next_s.cur_src = ACS_SRC_ADAT;
		end else begin
			next_s.cur_src = ACS_SRC_INT;
		end

		// Reference period and per-input status.
		next_s.ref_period = (s.cur_src == ACS_SRC_INT) ? int_period_i : mon[src_idx(s.cur_src)].period;
		for (int i = 0; i < 3; i++) begin
			if (!mon[i].locked) begin
				next_s.status[i] = ACS_ST_NOLOCK;
			end else if (acs_abs_diff(mon[i].period, s.ref_period) <= ACS_PER_TOL) begin
				next_s.status[i] = ACS_ST_SYNC;
			end else begin
				next_s.status[i] = ACS_ST_LOCK;
			end
		end

		// SPDIF rate report; zero period and no rate while unlocked.
		next_s.spdif_period = mon[1].locked ? mon[1].period : '0;
		next_s.spdif_rate = mon[1].locked ? acs_rate_of(mon[1].period) : ACS_RATE_NONE;

		// Internal oscillator divider.
		next_s.int_rise = 1'b0;
		if (s.int_cnt >= int_period_i - 1'b1) begin
			next_s.int_cnt = '0;
			next_s.int_rise = 1'b1;
		end else begin
			next_s.int_cnt = s.int_cnt + 1'b1;
		end

		// Word clock output: high for half of the output period from each accepted reference edge.
		if (s.wck_cnt != {(ACS_PW + 1){1'b1}}) begin
			next_s.wck_cnt = s.wck_cnt + 1'b1;
		end
		if (ref_rise && (!halve || !s.ss_phase)) begin
			next_s.wck = 1'b1;
			next_s.wck_cnt = '0;
		end else if (s.wck && (s.wck_cnt + 1'b1 >= (out_period >> 1))) begin
			next_s.wck = 1'b0;
		end
		if (ref_rise) begin
			next_s.ss_phase = halve ? !s.ss_phase : 1'b0;
		end

		// SPDIF transmit side.
		next_s.coax = spdif_tx_i;
		next_s.opt = spdif_cfg_i.opt_out_en & spdif_tx_i;
		next_s.tx_cs = spdif_cfg_i.tms_en & rx_cs_i;
		next_s.tx_tm = spdif_cfg_i.tms_en & rx_tm_i;

		// Box link state.
		next_s.box_sync = {s.box_sync[0], box_pins_i};
		case (s.box)
			ACS_BOX_ERROR: begin
				if (box_pins.present) begin
					next_s.box = ACS_BOX_DETECTED;
				end
			end
			ACS_BOX_DETECTED: begin
				if (!box_pins.present) begin
					next_s.box = ACS_BOX_ERROR;
				end else if (box_disconnect_i) begin
					next_s.box = ACS_BOX_DISCONNECTED;
				end else if (box_pins.fw_done && box_pins.comm_ok) begin
					next_s.box = ACS_BOX_CONNECTED;
				end
			end
			ACS_BOX_CONNECTED: begin
				if (box_disconnect_i) begin
					next_s.box = ACS_BOX_DISCONNECTED;
				end else if (!box_pins.present || !box_pins.comm_ok) begin
					next_s.box = ACS_BOX_ERROR;
				end
			end
			ACS_BOX_DISCONNECTED: begin
				if (!box_disconnect_i) begin
					next_s.box = box_pins.present ? ACS_BOX_DETECTED : ACS_BOX_ERROR;
				end
			end
			default: begin
				next_s.box = ACS_RST_BOX;
			end
		endcase
	end

	// ***************************************************************
	// Registers
	// ***************************************************************
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s <= '0;
			s.cur_src <= ACS_RST_SRC;
			s.box <= ACS_RST_BOX;
		end else begin
			s <= next_s;
		end
	end

	// ***************************************************************
	// Outputs
	// ***************************************************************
	assign cur_src_o = s.cur_src;
	assign word_status_o = s.status[0];
	assign spdif_status_o = s.status[1];
	assign adat_status_o = s.status[2];
	assign spdif_period_o = s.spdif_period;
	assign spdif_rate_o = s.spdif_rate;
	assign word_clk_o = s.wck;
	assign spdif_coax_o = s.coax;
	assign spdif_opt_o = s.opt;
	assign tx_cs_o = s.tx_cs;
	assign tx_tm_o = s.tx_tm;
	assign box_state_o = s.box;
	assign box_link_en_o = (s.box == ACS_BOX_DETECTED) || (s.box == ACS_BOX_CONNECTED);

endmodule
